// ==== logic/madi_map_pkg.sv ====
// Constants and types shared by the link channel mapper
package madi_map_pkg;
    // Rate modes, Gray coded along single, double, quad
    typedef enum logic [1:0] {
        RATE_SINGLE = 2'h0,
        RATE_DOUBLE = 2'h1,
        RATE_QUAD   = 2'h3
    } rate_mode_t;

    // Serializer states
    typedef enum logic {
        SER_IDLE = 1'h0,
        SER_SEND = 1'h1
    } ser_state_t;

    localparam int SAMPLE_W      = 24;
    localparam int LINK_CH       = 64;
    localparam int CH_W          = 6;
    localparam int NATIVE_CH     = 32;
    localparam int PER_W         = 16;
    // System clock and reference lock range
    localparam int SYS_CLK_HZ    = 125_000_000;
    localparam int REF_MAX_HZ    = 200_000;
    localparam int REF_MIN_HZ    = 25_000;
    // Shortest period rounds up, longest rounds down
    localparam int MIN_PER_CYC   = (SYS_CLK_HZ + REF_MAX_HZ - 1) / REF_MAX_HZ;
    localparam int MAX_PER_CYC   = SYS_CLK_HZ / REF_MIN_HZ;
    // Fixed digital path delay in samples
    localparam logic [3:0] LAT_SINGLE = 4'h3;
    localparam logic [3:0] LAT_DOUBLE = 4'h6;
    localparam logic [3:0] LAT_QUAD   = 4'hC;
    // Usable audio channels per mode
    localparam logic [6:0] CH_CNT_SINGLE = 7'h40;
    localparam logic [6:0] CH_CNT_DOUBLE = 7'h20;
    localparam logic [6:0] CH_CNT_QUAD   = 7'h10;
    // Period filter weight, as a shift
    localparam int FILT_SH       = 3;
endpackage

// ==== logic/madi_sample_mux_channel_mapper.sv ====
// Reference clock cleaner and link channel mapper with sample multiplexing
// Notes on behaviour
// - Double rate runs the internal sample clock at twice the base rate.
// - Samples stay 24 bits wide in every rate mode.
// - Double rate material goes either multiplexed in base frames or native.
// - Double rate base frame: one audio channel over two link channels, 32.
// - Quad rate base frame: one audio channel over four link channels, 16.
// - Multiplexed high rates keep the link at the base frame rate.
// - Quad rate uses only four-way multiplexing, never a native fast frame.
// - Successive samples of a channel go to successive carrier channels.
// - Clock recovery locks to references from 25 kHz to 200 kHz.
// - Cleaned clock feeds word clock output and transmitter timing.
// - Path delay of 3, 6 or 12 samples is reported as latency offset.
`timescale 1ns/10ps
`default_nettype none
module madi_sample_mux_channel_mapper
    import madi_map_pkg::*;
#(
    parameter int MAX_PER = madi_map_pkg::MAX_PER_CYC
) (
    // Clock and reset
    input  wire logic                            sys_clk,
    input  wire logic                            rstn,
    // Reference clock pin and mode selection
    input  wire logic                            ref_clk_pin,
    input  wire madi_map_pkg::rate_mode_t        rate_mode,
    input  wire logic                            native_frame_sel,
    // Audio samples toward the link
    input  wire logic                            aud_tx_valid,
    input  wire logic [madi_map_pkg::CH_W-1:0]   aud_tx_chan,
    input  wire logic [1:0]                      aud_tx_sub,
    input  wire logic [madi_map_pkg::SAMPLE_W-1:0] aud_tx_data,
    output var  logic                            aud_tx_ready,
    // Link slots out to the transmitter
    output var  logic                            link_tx_valid,
    output var  logic [madi_map_pkg::CH_W-1:0]   link_tx_slot,
    output var  logic [madi_map_pkg::SAMPLE_W-1:0] link_tx_data,
    // Link slots in from the receiver
    input  wire logic                            link_rx_valid,
    input  wire logic [madi_map_pkg::CH_W-1:0]   link_rx_slot,
    input  wire logic [madi_map_pkg::SAMPLE_W-1:0] link_rx_data,
    // Audio samples from the link
    output var  logic                            aud_rx_valid,
    output var  logic [madi_map_pkg::CH_W-1:0]   aud_rx_chan,
    output var  logic [1:0]                      aud_rx_sub,
    output var  logic [madi_map_pkg::SAMPLE_W-1:0] aud_rx_data,
    // Clocking and status
    output var  logic                            word_clk_out,
    output var  logic                            frame_tick,
    output var  logic                            sample_tick,
    output var  logic                            locked,
    output var  logic                            native_active,
    output var  logic [6:0]                      usable_ch,
    output var  logic [3:0]                      latency_offset
);
    localparam logic [PER_W-1:0] PMIN = PER_W'(MIN_PER_CYC);
    localparam logic [PER_W-1:0] PMAX = PER_W'(MAX_PER);

    logic             ref_s1_reg, ref_s2_reg, ref_s3_reg;
    logic [PER_W-1:0] per_cnt_reg, per_avg_reg, gen_cnt_reg;
    logic             good_reg;
    logic             locked_reg;
    logic             wclk_reg, frame_reg, stick_reg, native_reg;
    logic [6:0]       usable_reg;
    logic [3:0]       lat_reg;
    ser_state_t       ser_state_reg;
    logic [CH_W-1:0]  ser_slot_reg;
    logic             ltx_valid_reg;
    logic [CH_W-1:0]  ltx_slot_reg;
    logic [SAMPLE_W-1:0] ltx_data_reg;
    logic             arx_valid_reg;
    logic [CH_W-1:0]  arx_chan_reg;
    logic [1:0]       arx_sub_reg;
    logic [SAMPLE_W-1:0] arx_data_reg;
    logic             ready_reg;
    logic [SAMPLE_W-1:0] tx_mem [LINK_CH];

    // Reference edge and period measurement
    wire ref_rise  = ref_s2_reg & ~ref_s3_reg;
    wire per_ok    = (per_cnt_reg >= PMIN) && (per_cnt_reg <= PMAX);
    wire per_over  = per_cnt_reg > PMAX;
    wire [PER_W-1:0] per_avg_next = per_avg_reg
        + PER_W'((per_cnt_reg >> FILT_SH))
        - PER_W'((per_avg_reg >> FILT_SH));

    // Regenerated clock phase points
    wire gen_wrap  = gen_cnt_reg >= per_avg_reg - PER_W'(1);
    wire [PER_W-1:0] half_p = per_avg_reg >> 1;
    wire [PER_W-1:0] qtr_p  = per_avg_reg >> 2;
    wire base_tick = locked_reg & gen_wrap;
    wire is_double = rate_mode == RATE_DOUBLE;
    wire is_quad   = rate_mode == RATE_QUAD;
    wire mid_tick  = locked_reg & (is_double | is_quad)
                     & (gen_cnt_reg == half_p);
    wire qtr_tick  = locked_reg & is_quad
                     & ((gen_cnt_reg == qtr_p)
                     | (gen_cnt_reg == half_p + qtr_p));
    wire stick_next = base_tick | mid_tick | qtr_tick;

    // Native frame only for double rate, never for quad
    wire native_next = native_frame_sel & is_double;
    // Frame rate: base tick when multiplexed, double in native frames
    wire frame_next  = native_next ? stick_next : base_tick;

    // Multiplex factor as a shift
    wire [1:0] mux_sh = native_next ? 2'h0 :
                        is_quad     ? 2'h2 :
                        is_double   ? 2'h1 : 2'h0;
    wire [6:0] usable_next = native_next ? 7'(NATIVE_CH) :
                             is_quad     ? CH_CNT_QUAD :
                             is_double   ? CH_CNT_DOUBLE : CH_CNT_SINGLE;
    wire [3:0] lat_next = is_quad   ? LAT_QUAD :
                          is_double ? LAT_DOUBLE : LAT_SINGLE;

    // Transmit address: channel times factor plus sample index
    wire [1:0] sub_mask = mux_sh == 2'h2 ? 2'h3 :
                          mux_sh == 2'h1 ? 2'h1 : 2'h0;
    wire [CH_W-1:0] tx_addr = CH_W'(aud_tx_chan << mux_sh)
                              | CH_W'(aud_tx_sub & sub_mask);
    wire tx_in_range = {1'b0, aud_tx_chan} < usable_reg;
    wire tx_take     = aud_tx_valid & ready_reg & tx_in_range;
    wire [CH_W-1:0] last_slot = native_reg ? CH_W'(NATIVE_CH - 1)
                                           : CH_W'(LINK_CH - 1);

    // Receive demux: group index and position within group
    wire [1:0]      rx_sub  = link_rx_slot[1:0] & sub_mask;
    wire [CH_W-1:0] rx_chan = link_rx_slot >> mux_sh;
    wire rx_ok = link_rx_valid & ({1'b0, link_rx_slot} < (native_next
                 ? 7'(NATIVE_CH) : 7'(LINK_CH)));

    // Two-stage synchroniser, third stage only for edge finding
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ref_s1_reg <= 1'b0;
            ref_s2_reg <= 1'b0;
            ref_s3_reg <= 1'b0;
        end else begin
            ref_s1_reg <= ref_clk_pin;
            ref_s2_reg <= ref_s1_reg;
            ref_s3_reg <= ref_s2_reg;
        end
    end

    // Period counter; saturates so a dead input reads as over range
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            per_cnt_reg <= '0;
        else if (ref_rise)
            per_cnt_reg <= PER_W'(1);
        else if (!per_over)
            per_cnt_reg <= per_cnt_reg + PER_W'(1);
    end

    // Lock needs two good periods in a row; filter smooths jitter
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            good_reg    <= 1'b0;
            locked_reg  <= 1'b0;
            per_avg_reg <= PMAX;
        end else if (per_over) begin
            good_reg   <= 1'b0;
            locked_reg <= 1'b0;
        end else if (ref_rise) begin
            good_reg    <= per_ok;
            locked_reg  <= per_ok & good_reg;
            per_avg_reg <= good_reg ? per_avg_next : per_cnt_reg;
        end
    end

    // Regenerated clock runs free of input jitter
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            gen_cnt_reg <= '0;
        else if (!locked_reg || gen_wrap)
            gen_cnt_reg <= '0;
        else
            gen_cnt_reg <= gen_cnt_reg + PER_W'(1);
    end

    // Clock outputs and mode status
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wclk_reg   <= 1'b0;
            frame_reg  <= 1'b0;
            stick_reg  <= 1'b0;
            native_reg <= 1'b0;
            usable_reg <= CH_CNT_SINGLE;
            lat_reg    <= LAT_SINGLE;
            ready_reg  <= 1'b0;
        end else begin
            wclk_reg   <= locked_reg & (gen_cnt_reg < half_p);
            frame_reg  <= frame_next;
            stick_reg  <= stick_next;
            native_reg <= native_next;
            usable_reg <= usable_next;
            lat_reg    <= lat_next;
            ready_reg  <= locked_reg;
        end
    end

    // Sample store; no reset so it maps onto memory
    always_ff @(posedge sys_clk) begin
        if (tx_take)
            tx_mem[tx_addr] <= aud_tx_data;
    end

    // Slot serializer, started by the frame tick
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ser_state_reg <= SER_IDLE;
            ser_slot_reg  <= '0;
        end else begin
            case (ser_state_reg)
                SER_IDLE: begin
                    ser_slot_reg <= '0;
                    if (frame_reg)
                        ser_state_reg <= SER_SEND;
                end
                SER_SEND: begin
                    ser_slot_reg <= ser_slot_reg + CH_W'(1);
                    if (ser_slot_reg == last_slot)
                        ser_state_reg <= SER_IDLE;
                end
                default: ser_state_reg <= SER_IDLE;
            endcase
        end
    end

    // Link transmit slots, lowest slot first
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ltx_valid_reg <= 1'b0;
            ltx_slot_reg  <= '0;
            ltx_data_reg  <= '0;
        end else begin
            ltx_valid_reg <= ser_state_reg == SER_SEND;
            ltx_slot_reg  <= ser_slot_reg;
            ltx_data_reg  <= tx_mem[ser_slot_reg];
        end
    end

    // Receive side demultiplex back to audio channels
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            arx_valid_reg <= 1'b0;
            arx_chan_reg  <= '0;
            arx_sub_reg   <= '0;
            arx_data_reg  <= '0;
        end else begin
            arx_valid_reg <= rx_ok;
            arx_chan_reg  <= rx_chan;
            arx_sub_reg   <= rx_sub;
            arx_data_reg  <= link_rx_data;
        end
    end

    assign aud_tx_ready   = ready_reg;
    assign link_tx_valid  = ltx_valid_reg;
    assign link_tx_slot   = ltx_slot_reg;
    assign link_tx_data   = ltx_data_reg;
    assign aud_rx_valid   = arx_valid_reg;
    assign aud_rx_chan    = arx_chan_reg;
    assign aud_rx_sub     = arx_sub_reg;
    assign aud_rx_data    = arx_data_reg;
    assign word_clk_out   = wclk_reg;
    assign frame_tick     = frame_reg;
    assign sample_tick    = stick_reg;
    assign locked         = locked_reg;
    assign native_active  = native_reg;
    assign usable_ch      = usable_reg;
    assign latency_offset = lat_reg;

    // Checks on the behaviour above
    sequence s_double_base;
        is_double && !native_frame_sel;
    endsequence

    sequence s_tx_write;
        tx_take ##1 1'b1;
    endsequence

    a_wclk_unlocked: assert property (@(posedge sys_clk) disable iff (!rstn)
        !$past(locked_reg) |-> !word_clk_out && !frame_tick)
        else $error("word clock or frame while unlocked");

    a_mid_tick_dbl: assert property (@(posedge sys_clk) disable iff (!rstn)
        locked_reg && is_double && !native_frame_sel
        && $stable(per_avg_reg) && gen_cnt_reg == half_p
        |=> sample_tick && !frame_tick)
        else $error("double rate mid sample tick missing");

    a_double_count: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_double_base |=> usable_ch == 7'h20 && latency_offset == 4'h6)
        else $error("double rate channel count or latency wrong");

    a_quad_count: assert property (@(posedge sys_clk) disable iff (!rstn)
        is_quad |=> usable_ch == 7'h10 && !native_active)
        else $error("quad rate count or frame wrong");

    a_quad_no_native: assert property (@(posedge sys_clk) disable iff (!rstn)
        is_quad && native_frame_sel |=> !native_active)
        else $error("native frame used at quad rate");

    a_base_frame_rate: assert property (@(posedge sys_clk) disable iff (!rstn)
        !native_next && !base_tick |=> !frame_tick)
        else $error("base frame tick off the base clock");

    a_tx_store_map: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_tx_write |-> tx_mem[$past(tx_addr)] == $past(aud_tx_data))
        else $error("sample not stored at mapped slot");

    a_rx_demux_dbl: assert property (@(posedge sys_clk) disable iff (!rstn)
        (s_double_base and link_rx_valid) |=> aud_rx_valid
        && aud_rx_sub == {1'b0, $past(link_rx_slot[0])}
        && aud_rx_chan == $past(link_rx_slot) >> 1)
        else $error("double rate receive demux wrong");

    a_lock_needs_range: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(locked_reg) |-> $past(ref_rise) && $past(per_ok))
        else $error("lock without in-range period");

    a_ser_length: assert property (@(posedge sys_clk) disable iff (!rstn)
        ser_state_reg == SER_IDLE && frame_reg && !native_reg
        |=> (ser_state_reg == SER_SEND) [*8])
        else $error("frame serializer stopped early");
endmodule // madi_sample_mux_channel_mapper
`default_nettype wire

// ==== tb/madi_far_end.sv ====
// Far-end audio device model: reference clock and received link slots
`timescale 1ns/10ps
`default_nettype none
module madi_far_end
    import madi_map_pkg::*;
(
    // Clock
    input  wire logic                             sys_clk,
    // Toward the mapper
    output var  logic                             ref_clk_pin,
    output var  logic                             link_rx_valid,
    output var  logic [madi_map_pkg::CH_W-1:0]    link_rx_slot,
    output var  logic [madi_map_pkg::SAMPLE_W-1:0] link_rx_data
);
    real half_ns = 0.0;

    // Quiet pins at time zero
    initial begin
        ref_clk_pin = 1'b0;
        link_rx_valid = 1'b0;
        link_rx_slot = 6'h00;
        link_rx_data = 24'h000000;
    end

    // Free running base-rate word clock, no phase tie to sys_clk
    always begin
        if (half_ns > 0.0) begin
            #(half_ns) ref_clk_pin = ~ref_clk_pin;
        end else begin
            #50;
        end
    end

    // One slot; lines show the inverse once released so stale data misleads
    task automatic send_slot(input logic [5:0] s, input logic [23:0] d);
        @(posedge sys_clk);
        link_rx_valid <= 1'b1;
        link_rx_slot <= s;
        link_rx_data <= d;
        @(posedge sys_clk);
        link_rx_valid <= 1'b0;
        link_rx_slot <= ~s;
        link_rx_data <= ~d;
    endtask
endmodule // madi_far_end
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the link channel mapper
`timescale 1ns/10ps
`default_nettype none
module tb;
    import madi_map_pkg::*;
    logic            sys_clk = 1'b0;
    logic            rstn = 1'b0;
    rate_mode_t      rate_mode = RATE_SINGLE;
    logic            native_frame_sel = 1'b0;
    logic            aud_tx_valid = 1'b0;
    logic [5:0]      aud_tx_chan = 6'h00;
    logic [1:0]      aud_tx_sub = 2'h0;
    logic [23:0]     aud_tx_data = 24'h000000;
    logic            ref_clk_pin, link_rx_valid, aud_tx_ready, link_tx_valid;
    logic [5:0]      link_rx_slot, link_tx_slot, aud_rx_chan;
    logic [23:0]     link_rx_data, link_tx_data, aud_rx_data;
    logic            aud_rx_valid, word_clk_out, frame_tick, sample_tick;
    logic            locked, native_active;
    logic [1:0]      aud_rx_sub;
    logic [6:0]      usable_ch;
    logic [3:0]      latency_offset;
    logic [23:0]     frame_buf [64];
    int              err_total = 0;
    int              checked = 0;

    // Shortened lock window keeps the run brief
    madi_sample_mux_channel_mapper #(.MAX_PER(1000))
        madi_sample_mux_channel_mapper_inst (.sys_clk, .rstn, .ref_clk_pin,
        .rate_mode, .native_frame_sel, .aud_tx_valid, .aud_tx_chan,
        .aud_tx_sub, .aud_tx_data, .aud_tx_ready, .link_tx_valid,
        .link_tx_slot, .link_tx_data, .link_rx_valid, .link_rx_slot,
        .link_rx_data, .aud_rx_valid, .aud_rx_chan, .aud_rx_sub,
        .aud_rx_data, .word_clk_out, .frame_tick, .sample_tick, .locked,
        .native_active, .usable_ch, .latency_offset);
    madi_far_end madi_far_end_inst (.sys_clk, .ref_clk_pin, .link_rx_valid,
        .link_rx_slot, .link_rx_data);

    // 125 MHz system clock
    always #4 sys_clk = ~sys_clk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic set_mode(input logic [1:0] m, input logic nat);
        @(posedge sys_clk);
        rate_mode <= rate_mode_t'(m);
        native_frame_sel <= nat;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    task automatic put(input logic [5:0] c, input logic [1:0] s,
                       input logic [23:0] d);
        @(posedge sys_clk);
        aud_tx_valid <= 1'b1;
        aud_tx_chan <= c;
        aud_tx_sub <= s;
        aud_tx_data <= d;
        @(posedge sys_clk);
        aud_tx_valid <= 1'b0;
    endtask

    task automatic wait_frame;
        int k;
        k = 0;
        do begin
            @(posedge sys_clk);
            #1;
            k++;
        end while (frame_tick !== 1'b1 && k < 2000);
        check(frame_tick, 1'b1, "frame tick");
    endtask

    // Collect one frame of slots in order
    task automatic grab_frame;
        int n;
        wait_frame();
        n = 0;
        repeat (70) begin
            @(posedge sys_clk);
            #1;
            if (link_tx_valid === 1'b1) begin
                check(link_tx_slot, n & 63, "slot order");
                frame_buf[n & 63] = link_tx_data;
                n++;
            end
        end
        check(n, 64, "slots per frame");
    endtask

    task automatic t_lock;
        int n;
        logic wprev;
        madi_far_end_inst.half_ns = 62.5;
        repeat (3000) @(posedge sys_clk);
        #1;
        check(locked, 1'b0, "lock on too fast ref");
        madi_far_end_inst.half_ns = 3200.0;
        n = 0;
        while (locked !== 1'b1 && n < 5000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check(locked, 1'b1, "lock on 156 kHz ref");
        repeat (2) @(posedge sys_clk);
        #1;
        check(aud_tx_ready, 1'b1, "ready after lock");
        n = 0;
        wprev = word_clk_out;
        repeat (4000) begin
            @(posedge sys_clk);
            #1;
            n += (word_clk_out === 1'b1 && wprev !== 1'b1) ? 1 : 0;
            wprev = word_clk_out;
        end
        check(32'(n >= 4 && n <= 6), 1, "word clock rate");
        $display("test lock done");
    endtask

    task automatic t_modes;
        logic [1:0] md [6] = '{2'h0, 2'h1, 2'h3, 2'h1, 2'h3, 2'h2};
        logic       sel [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        logic [6:0] uc [6] = '{7'h40, 7'h20, 7'h10, 7'h20, 7'h10, 7'h40};
        logic [3:0] lt [6] = '{4'h3, 4'h6, 4'hC, 4'h6, 4'hC, 4'h3};
        int         tk [6] = '{4, 8, 16, 4, 16, 4};
        int         fi [6] = '{800, 800, 800, 400, 800, 800};
        int         st, cyc, fr;
        for (int i = 0; i < 6; i++) begin
            set_mode(md[i], sel[i]);
            check(usable_ch, uc[i], "usable channels");
            check(latency_offset, lt[i], "latency offset");
            check(native_active, sel[i] & (md[i] == 2'h1), "native");
            wait_frame();
            st = 0;
            cyc = 0;
            fr = 0;
            while (fr < 4 && cyc < 5000) begin
                @(posedge sys_clk);
                #1;
                cyc++;
                st += sample_tick;
                fr += frame_tick;
            end
            check(32'(st >= tk[i] - 1 && st <= tk[i] + 1), 1, "ticks");
            check(32'(cyc >= 4 * fi[i] - 16 && cyc <= 4 * fi[i] + 16), 1,
                  "frame spacing");
        end
        $display("test modes done");
    endtask

    task automatic t_tx;
        set_mode(2'h1, 1'b0);
        put(6'h00, 2'h0, 24'h111111);
        put(6'h01, 2'h0, 24'hF0000A);
        put(6'h01, 2'h1, 24'h0F000B);
        put(6'h1F, 2'h1, 24'h80000C);
        put(6'h20, 2'h0, 24'hBAD000);
        grab_frame();
        check(frame_buf[0], 24'h111111, "refused channel");
        check(frame_buf[2], 24'hF0000A, "double sub0");
        check(frame_buf[3], 24'h0F000B, "double sub1");
        check(frame_buf[63], 24'h80000C, "last pair");
        set_mode(2'h3, 1'b0);
        for (int s = 0; s < 4; s++) put(6'h03, 2'(s), 24'hC0DE00 + 24'(s));
        put(6'h10, 2'h0, 24'hBAD111);
        grab_frame();
        for (int s = 0; s < 4; s++)
            check(frame_buf[12 + s], 24'hC0DE00 + 24'(s), "quad");
        check(frame_buf[0], 24'h111111, "quad refused");
        $display("test transmit done");
    endtask

    task automatic rx_one(input logic [5:0] s, input logic [8:0] exp);
        logic [8:0] got;
        madi_far_end_inst.send_slot(s, {s, 18'h2AAAA});
        #1;
        got = {aud_rx_valid, aud_rx_chan, aud_rx_sub};
        // Channel fields mean nothing on a dropped slot, only valid counts
        if (!exp[8])
            got[7:0] = 8'h00;
        check(got, exp, "demux");
        if (exp[8])
            check(aud_rx_data, {s, 18'h2AAAA}, "rx data");
    endtask

    task automatic t_rx;
        set_mode(2'h1, 1'b0);
        rx_one(6'h05, {1'b1, 6'h02, 2'h1});
        set_mode(2'h3, 1'b0);
        rx_one(6'h07, {1'b1, 6'h01, 2'h3});
        set_mode(2'h0, 1'b0);
        rx_one(6'h3F, {1'b1, 6'h3F, 2'h0});
        set_mode(2'h1, 1'b1);
        rx_one(6'h28, 9'h000);
        rx_one(6'h09, {1'b1, 6'h09, 2'h0});
        $display("test receive done");
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        #1;
        check(usable_ch, 7'h40, "reset channels");
        check(latency_offset, 4'h3, "reset latency");
        check(link_tx_valid, 1'b0, "reset idle");
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        t_lock();
        t_modes();
        t_tx();
        t_rx();
        report_and_stop();
    end

    // Watchdog sized well beyond the expected run
    initial begin
        #600000;
        err_total++;
        $display("[ERR] t=%0t watchdog expired", $time);
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
